// ---- core/psq_pkg.sv ----
// package: constants and carrier types for the program sequencer
package psq_pkg;
	localparam int unsigned PC_W_SMALL    = 10;
	localparam int unsigned PC_W_LARGE    = 11;
	localparam int unsigned DEPTH_SMALL   = 2;
	localparam int unsigned DEPTH_LARGE   = 4;
	localparam int unsigned WORD_W        = 14;
	localparam int unsigned BYTE_W        = 8;
	localparam logic [10:0] VEC_RESET     = 11'h000;
	localparam logic [10:0] VEC_EXT_INT   = 11'h004;
	localparam logic [10:0] VEC_TMR_INT   = 11'h008;
	localparam logic [1:0]  PHASE_RESET   = 2'h0;
	localparam logic [1:0]  PHASE_LAST    = 2'h3;

	// decoded instruction request from the decoder
	typedef struct packed {
		logic        step;
		logic        jump;
		logic        call;
		logic        ret_call;
		logic        ret_handler;
		logic        skip;
		logic        pcl_write;
		logic [7:0]  pcl_data;
		logic [10:0] target;
		logic        tbl_cur;
		logic        tbl_last;
		logic [7:0]  tbl_ptr;
		logic [6:0]  tbl_dest;
	} psq_instr_s;

	// table read result towards the data path
	typedef struct packed {
		logic        valid;
		logic [6:0]  dest;
		logic [7:0]  low;
		logic [7:0]  high;
	} psq_tbl_s;

	// sequencer state
	typedef enum logic [1:0] {
		PSQ_RUN    = 2'b00,
		PSQ_BRANCH = 2'b01,
		PSQ_TBL    = 2'b10
	} psq_state_e;
endpackage

// ---- core/psq_stack.sv ----
// return address stack with occupancy count
`timescale 1ns/1ps
`default_nettype none
module psq_stack #(
	parameter int unsigned PC_W  = 10,
	parameter int unsigned DEPTH = 2
) (
	// clock and reset
	input  wire logic            clock,
	input  wire logic            arst_n,
	// push and pop
	input  wire logic            push,
	input  wire logic            pop,
	input  wire logic [PC_W-1:0] push_data,
	// state
	output logic [PC_W-1:0]      top,
	output logic                 full
);
	localparam int unsigned IW = $clog2(DEPTH);

	logic [PC_W-1:0] entry      [DEPTH];
	logic [PC_W-1:0] next_entry [DEPTH];
	logic [IW-1:0]   stack_index;
	logic [IW-1:0]   next_stack_index;
	logic [IW:0]     level;
	logic [IW:0]     next_level;

	// ******************************
	// next stack contents
	// ******************************
	always_comb
	begin
		next_entry       = entry;
		next_stack_index = stack_index;
		next_level       = level;
		if (push)
		begin
			next_entry[stack_index] = push_data;
			next_stack_index        = IW'(stack_index + 1'b1);
			if (level != (IW+1)'(DEPTH))
				next_level = (IW+1)'(level + 1'b1);
		end
		else if (pop)
		begin
			next_stack_index = IW'(stack_index - 1'b1);
			if (level != '0)
				next_level = (IW+1)'(level - 1'b1);
		end
	end

	// ******************************
	// registers, no software path
	// ******************************
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < DEPTH; i++)
				entry[i] <= '0;
			stack_index <= '0;
			level       <= '0;
		end
		else
		begin
			entry       <= next_entry;
			stack_index <= next_stack_index;
			level       <= next_level;
		end
	end

	// outputs
	assign top  = entry[IW'(stack_index - 1'b1)];
	assign full = (level == (IW+1)'(DEPTH));
endmodule
`default_nettype wire

// ---- core/psq_sequencer.sv ----
// program sequencer: next address, stack control, interrupt gating, table read
`timescale 1ns/1ps
`default_nettype none
module psq_sequencer #(
	parameter int unsigned PC_W  = psq_pkg::PC_W_SMALL,
	parameter int unsigned DEPTH = psq_pkg::DEPTH_SMALL
) (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       arst_n,
	// instruction cycle enable and decoded request
	input  wire logic                       cycle_en,
	input  wire psq_pkg::psq_instr_s        instr,
	// interrupt sources (ext_int_n is a pin)
	input  wire logic                       ext_int_n,
	input  wire logic                       ext_int_en,
	input  wire logic                       tmr_ovf,
	input  wire logic                       tmr_int_en,
	input  wire logic                       ext_flag_clr,
	input  wire logic                       tmr_flag_clr,
	// alu status
	input  wire logic [3:0]                 alu_status,
	input  wire logic                       alu_status_we,
	// program memory
	output logic [PC_W-1:0]                 pmem_addr,
	input  wire logic [psq_pkg::WORD_W-1:0] pmem_data,
	// results
	output logic [PC_W-1:0]                 pc,
	output logic                            int_ack,
	output logic                            ext_flag,
	output logic                            tmr_flag,
	output logic                            stack_full,
	output logic                            busy,
	output psq_pkg::psq_tbl_s               tbl_out,
	output logic [psq_pkg::BYTE_W-1:0]      table_high_byte,
	output logic [3:0]                      status
);
	// synchroniser and sequencer state
	logic                  ext_s1;
	logic                  ext_s2;
	logic                  ext_prev;
	psq_pkg::psq_state_e   state;
	psq_pkg::psq_state_e   next_state;
	logic [PC_W-1:0]       next_pc;
	logic [PC_W-1:0]       pend_pc;
	logic [PC_W-1:0]       next_pend_pc;
	logic [PC_W-1:0]       next_pmem_addr;
	logic [6:0]            tbl_dest;
	logic [6:0]            next_tbl_dest;
	logic                  next_ext_flag;
	logic                  next_tmr_flag;
	// interrupt acknowledge requests
	logic                  ext_take;
	logic                  tmr_take;
	logic                  next_int_ack;
	logic                  next_busy;
	logic                  next_full;
	// stack interface
	logic                  push;
	logic                  pop;
	logic [PC_W-1:0]       push_data;
	logic [PC_W-1:0]       stk_top;
	logic                  stk_full;
	psq_pkg::psq_tbl_s     next_tbl_out;
	logic [7:0]            next_table_high_byte;
	logic [3:0]            next_status;

	// ******************************
	// page join: upper pc bits with a new low byte
	// ******************************
	function automatic logic [PC_W-1:0] page_join(
		input logic [PC_W-1:0] base,
		input logic [7:0]      low
	);
		page_join = {base[PC_W-1:8], low};
	endfunction

	// ******************************
	// return address stack
	// ******************************
	psq_stack #(
		.PC_W  (PC_W),
		.DEPTH (DEPTH)
	) u_stack (
		.clock     (clock),
		.arst_n    (arst_n),
		.push      (push),
		.pop       (pop),
		.push_data (push_data),
		.top       (stk_top),
		.full      (stk_full)
	);

	// ******************************
	// external pin synchroniser
	// ******************************
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ext_s1   <= 1'b1;
			ext_s2   <= 1'b1;
			ext_prev <= 1'b1;
		end
		else
		begin
			ext_s1   <= ext_int_n;
			ext_s2   <= ext_s1;
			ext_prev <= ext_s2;
		end
	end

	// ******************************
	// interrupt request flags
	// ******************************
	// set wins over clear or acknowledge; flags record even when stack full
	always_comb
	begin
		next_ext_flag = ext_flag;
		next_tmr_flag = tmr_flag;
		if (ext_flag_clr || ext_take)
			next_ext_flag = 1'b0;
		if (tmr_flag_clr || tmr_take)
			next_tmr_flag = 1'b0;
		if (ext_prev && !ext_s2)
			next_ext_flag = 1'b1;
		if (tmr_ovf)
			next_tmr_flag = 1'b1;
	end

	// flag registers
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			ext_flag <= 1'b0;
			tmr_flag <= 1'b0;
		end
		else
		begin
			ext_flag <= next_ext_flag;
			tmr_flag <= next_tmr_flag;
		end
	end

	// ******************************
	// next state and address
	// ******************************
	always_comb
	begin
		next_state           = state;
		next_pc              = pc;
		next_pend_pc         = pend_pc;
		next_tbl_dest        = tbl_dest;
		next_pmem_addr       = pmem_addr;
		next_int_ack         = 1'b0;
		push                 = 1'b0;
		pop                  = 1'b0;
		push_data            = pc;
		next_tbl_out         = '0;
		next_table_high_byte = table_high_byte;
		next_status          = status;
		ext_take             = 1'b0;
		tmr_take             = 1'b0;
		if (alu_status_we)
			next_status = alu_status;
		if (cycle_en)
		begin
			// interrupts first, then the decoded request
			case (state)
				psq_pkg::PSQ_RUN:
				begin
					if (ext_flag && ext_int_en && !stk_full)
					begin
						push         = 1'b1;
						next_pc      = PC_W'(psq_pkg::VEC_EXT_INT);
						ext_take     = 1'b1;
						next_int_ack = 1'b1;
					end
					else if (tmr_flag && tmr_int_en && !stk_full)
					begin
						push         = 1'b1;
						next_pc      = PC_W'(psq_pkg::VEC_TMR_INT);
						tmr_take     = 1'b1;
						next_int_ack = 1'b1;
					end
					else if (instr.jump || instr.call)
					begin
						push         = instr.call;
						push_data    = PC_W'(pc + 1'b1);
						next_pend_pc = instr.target[PC_W-1:0];
						next_state   = psq_pkg::PSQ_BRANCH;
					end
					else if (instr.ret_call || instr.ret_handler)
					begin
						pop          = 1'b1;
						next_pend_pc = stk_top;
						next_state   = psq_pkg::PSQ_BRANCH;
					end
					else if (instr.pcl_write)
					begin
						next_pend_pc = page_join(pc, instr.pcl_data);
						next_state   = psq_pkg::PSQ_BRANCH;
					end
					else if (instr.tbl_cur || instr.tbl_last)
					begin
						// upper bits from current page or all ones
						next_pmem_addr = instr.tbl_cur ?
							page_join(pc, instr.tbl_ptr) :
							page_join('1, instr.tbl_ptr);
						next_tbl_dest  = instr.tbl_dest;
						next_pc        = PC_W'(pc + 1'b1);
						next_state     = psq_pkg::PSQ_TBL;
					end
					else if (instr.skip)
						next_pc = PC_W'(pc + 2'h2);
					else if (instr.step)
						next_pc = PC_W'(pc + 1'b1);
				end
				// second cycle of a branch
				psq_pkg::PSQ_BRANCH:
				begin
					next_pc    = pend_pc;
					next_state = psq_pkg::PSQ_RUN;
				end
				// second cycle of a table read
				psq_pkg::PSQ_TBL:
				begin
					next_tbl_out.valid   = 1'b1;
					next_tbl_out.dest    = tbl_dest;
					next_tbl_out.low     = pmem_data[7:0];
					next_table_high_byte = {2'h0, pmem_data[psq_pkg::WORD_W-1:8]};
					next_tbl_out.high    = next_table_high_byte;
					next_state           = psq_pkg::PSQ_RUN;
				end
				default:
					next_state = psq_pkg::PSQ_RUN;
			endcase
			if (next_state != psq_pkg::PSQ_TBL)
				next_pmem_addr = next_pc;
		end
		next_busy = (next_state != psq_pkg::PSQ_RUN);
		next_full = stk_full;
	end

	// ******************************
	// sequencer registers
	// ******************************
	always_ff @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state           <= psq_pkg::PSQ_RUN;
			pc              <= PC_W'(psq_pkg::VEC_RESET);
			pmem_addr       <= PC_W'(psq_pkg::VEC_RESET);
			pend_pc         <= '0;
			tbl_dest        <= '0;
			int_ack         <= 1'b0;
			stack_full      <= 1'b0;
			busy            <= 1'b0;
			tbl_out         <= '0;
			table_high_byte <= '0;
			status          <= '0;
		end
		else
		begin
			state           <= next_state;
			pc              <= next_pc;
			pmem_addr       <= next_pmem_addr;
			pend_pc         <= next_pend_pc;
			tbl_dest        <= next_tbl_dest;
			int_ack         <= next_int_ack;
			stack_full      <= next_full;
			busy            <= next_busy;
			tbl_out         <= next_tbl_out;
			table_high_byte <= next_table_high_byte;
			status          <= next_status;
		end
	end
endmodule
`default_nettype wire

// ---- verification/psq_props.sv ----
// checker: port assertions for the program sequencer
`timescale 1ns/1ps
`default_nettype none
module psq_props #(
	parameter int unsigned PC_W  = 10,
	parameter int unsigned DEPTH = 2
) (
	// clock, reset and requests
	input wire logic                clock,
	input wire logic                arst_n,
	input wire logic                cycle_en,
	input wire psq_pkg::psq_instr_s instr,
	input wire logic                ext_int_n,
	input wire logic                ext_int_en,
	input wire logic                tmr_ovf,
	input wire logic                tmr_int_en,
	input wire logic [3:0]          alu_status,
	input wire logic                alu_status_we,
	// results
	input wire logic [PC_W-1:0]     pc,
	input wire logic [PC_W-1:0]     pmem_addr,
	input wire logic                int_ack,
	input wire logic                ext_flag,
	input wire logic                tmr_flag,
	input wire logic                busy,
	input wire psq_pkg::psq_tbl_s   tbl_out,
	input wire logic [7:0]          table_high_byte,
	input wire logic [3:0]          status
);
	// ****************
	// properties
	// ****************
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// no interrupt pending, instruction not refused
	wire quiet = ~(ext_flag & ext_int_en) & ~(tmr_flag & tmr_int_en) & cycle_en & ~busy;
	wire plain = instr.step & ~|{instr.jump, instr.call, instr.ret_call, instr.ret_handler,
		instr.skip, instr.pcl_write, instr.tbl_cur, instr.tbl_last};
	sequence ext_seen;
		##[1:4] ext_flag;
	endsequence
	a_reset_clear: assert property (disable iff (1'b0) !arst_n |-> pc == '0)
		else $error("pc not cleared in reset");
	a_pc_step: assert property (quiet && plain |=> pc == PC_W'($past(pc) + 1))
		else $error("pc did not advance by one");
	a_call_busy: assert property (quiet && instr.call |=> busy)
		else $error("call not given a second cycle");
	a_ack_vector: assert property (int_ack |-> pc == 'h4 || pc == 'h8)
		else $error("acknowledge without vector");
	a_ext_flag: assert property ($fell(ext_int_n) |-> ext_seen)
		else $error("external flag not set");
	a_tmr_flag: assert property (tmr_ovf |=> tmr_flag)
		else $error("timer flag not set");
	a_tbl_pulse: assert property (tbl_out.valid |=> !tbl_out.valid)
		else $error("table valid longer than one clock");
	a_tbl_high: assert property (tbl_out.valid |-> table_high_byte == tbl_out.high)
		else $error("table high byte mismatch");
	a_status_load: assert property (alu_status_we |=> status == $past(alu_status))
		else $error("status not loaded");
endmodule
bind psq_sequencer psq_props #(.PC_W(PC_W), .DEPTH(DEPTH)) psq_props_inst (.*);
`default_nettype wire

// ---- verification/psq_pmem_model.sv ----
// program memory model: word pattern built from the address
`timescale 1ns/1ps
`default_nettype none
module psq_pmem_model (
	// fetch address and word
	input wire logic [9:0] addr,
	output logic [13:0]    data
);
	// high part echoes address bits 9 to 4, low byte the offset
	assign data = {addr[9:4], addr[7:0]};
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// testbench: scenario tasks for the program sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                clock, arst_n, cycle_en, ext_int_n, ext_int_en, tmr_ovf, tmr_int_en;
	logic                ext_flag_clr, tmr_flag_clr, alu_status_we, int_ack, ext_flag;
	logic                tmr_flag, stack_full, busy, ack, valid;
	logic [3:0]          alu_status, status;
	logic [9:0]          pmem_addr, pc;
	logic [13:0]         pmem_data;
	logic [7:0]          table_high_byte;
	psq_pkg::psq_instr_s instr;
	psq_pkg::psq_tbl_s   tbl_out;
	int                  fails, checks;
	psq_sequencer #(.PC_W(10), .DEPTH(2)) psq_sequencer_inst (.clock(clock), .arst_n(arst_n),
		.cycle_en(cycle_en), .instr(instr), .ext_int_n(ext_int_n), .ext_int_en(ext_int_en),
		.tmr_ovf(tmr_ovf), .tmr_int_en(tmr_int_en), .ext_flag_clr(ext_flag_clr),
		.tmr_flag_clr(tmr_flag_clr), .alu_status(alu_status), .alu_status_we(alu_status_we),
		.pmem_addr(pmem_addr), .pmem_data(pmem_data), .pc(pc), .int_ack(int_ack),
		.ext_flag(ext_flag), .tmr_flag(tmr_flag), .stack_full(stack_full), .busy(busy),
		.tbl_out(tbl_out), .table_high_byte(table_high_byte), .status(status));
	psq_pmem_model psq_pmem_model_inst (.addr(pmem_addr), .data(pmem_data));
	// ****************
	// helpers
	// ****************
	initial
	begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end
	task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
		checks++;
		if (e !== g)
		begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	// one instruction cycle: k picks step,jump,call,ret,return_from_handler,skip,pcl,tbl cur,tbl last
	task automatic op(input int k, input logic [10:0] a);
		psq_pkg::psq_instr_s x;
		x = '0;
		{x.step, x.jump, x.call, x.ret_call, x.ret_handler, x.skip, x.pcl_write, x.tbl_cur,
			x.tbl_last} = 9'h100 >> k;
		{x.target, x.pcl_data, x.tbl_ptr, x.tbl_dest} = {a, a[7:0], a[7:0], 7'h05};
		@(posedge clock);
		cycle_en <= 1'b1;
		instr    <= x;
		@(posedge clock);
		cycle_en <= 1'b0;
		#1;
		ack   = int_ack;
		valid = tbl_out.valid;
	endtask
	// one-clock pulse: w picks timer overflow, timer clear, external clear, status write
	task automatic pulse(input int w);
		@(posedge clock);
		{tmr_ovf, tmr_flag_clr, ext_flag_clr, alu_status_we} <= 4'h8 >> w;
		@(posedge clock);
		{tmr_ovf, tmr_flag_clr, ext_flag_clr, alu_status_we} <= 4'h0;
	endtask
	task automatic rst;
		@(posedge clock);
		arst_n <= 1'b0;
		repeat (10) @(posedge clock);
		arst_n <= 1'b1;
		#1;
		chk("pc", 11'h000, pc);
		chk("full", 11'h000, stack_full);
	endtask
	task automatic print_verdict;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_flow;
		op(0, 0);
		op(0, 0);
		chk("pc", 11'h002, pc);
		op(5, 0);
		chk("pc", 11'h004, pc);
		op(1, 11'h155);
		chk("busy", 11'h001, busy);
		op(0, 0);
		chk("pc", 11'h155, pc);
		op(6, 11'h03c);
		op(0, 0);
		chk("pc", 11'h13c, pc);
	endtask
	task automatic t_stack;
		op(2, 11'h200);
		op(0, 0);
		op(2, 11'h280);
		op(0, 0);
		chk("full", 11'h001, stack_full);
		pulse(0);
		op(0, 0);
		chk("ack", 11'h000, ack);
		chk("tflag", 11'h001, tmr_flag);
		op(3, 0);
		op(0, 0);
		chk("pc", 11'h201, pc);
		op(0, 0);
		chk("ack", 11'h001, ack);
		chk("pc", 11'h008, pc);
		pulse(1);
		op(4, 0);
		op(0, 0);
		chk("pc", 11'h201, pc);
		op(3, 0);
		op(0, 0);
		chk("pc", 11'h13d, pc);
	endtask
	task automatic t_ext;
		@(posedge clock);
		ext_int_n <= 1'b0;
		repeat (5) @(posedge clock);
		chk("eflag", 11'h001, ext_flag);
		op(0, 0);
		chk("ack", 11'h001, ack);
		chk("pc", 11'h004, pc);
		@(posedge clock);
		ext_int_n <= 1'b1;
		pulse(2);
		op(4, 0);
		op(0, 0);
		chk("pc", 11'h13d, pc);
	endtask
	task automatic t_table;
		op(8, 11'h046);
		chk("busy", 11'h001, busy);
		op(0, 0);
		chk("valid", 11'h001, valid);
		chk("low", 11'h046, tbl_out.low);
		chk("high", 11'h034, table_high_byte);
		chk("dest", 11'h005, tbl_out.dest);
		op(7, 11'h09a);
		op(0, 0);
		chk("high", 11'h019, table_high_byte);
		chk("addr", 11'h13f, pmem_addr);
		pulse(3);
		#1;
		chk("status", 11'h00a, status);
	endtask
	task automatic t_overflow;
		op(2, 11'h300);
		op(0, 0);
		op(2, 11'h380);
		op(0, 0);
		op(2, 11'h3c0);
		op(0, 0);
		chk("pc", 11'h3c0, pc);
	endtask
	initial
	begin
		{arst_n, cycle_en, tmr_ovf, ext_flag_clr, tmr_flag_clr, alu_status_we} = '0;
		{ext_int_n, ext_int_en, tmr_int_en} = 3'h7;
		instr      = '0;
		fails      = 0;
		checks     = 0;
		alu_status = 4'ha;
		rst();
		t_flow();
		t_stack();
		t_ext();
		t_table();
		t_overflow();
		rst();
		print_verdict();
	end
endmodule
`default_nettype wire
